// ==== bench/acrc_host_model.sv ====
// host-side model: drives the converter's control, clock and read pins
// assumes one system clock; every pin change lands just after its edge
module acrc_host_model
    import acrc_pkg::*;
(
    // clock
    input wire logic sys_clk_i,
    // pins toward the converter
    output logic start_o,
    output logic pdown_o,
    output logic strap_o,
    output logic ext_clk_o,
    output logic sel_n_o,
    output logic rd_n_o,
    // pins from the converters (second one shares the strobes)
    input wire logic [RESULT_W-1:0] bus_i,
    input wire logic [RESULT_W-1:0] bus2_i,
    input wire logic oe_i
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [RESULT_W-1:0] bus_wire;
    logic [RESULT_W-1:0] bus2_wire;

    // what the host sees: an undriven bus floats
    assign bus_wire = oe_i ? bus_i : 'z;
    assign bus2_wire = oe_i ? bus2_i : 'z;

    // idle pins: tracking, awake, strobes high, conversion clock still
    initial begin
        start_o = 1'b0;
        pdown_o = 1'b0;
        strap_o = 1'b1;
        ext_clk_o = 1'b0;
        sel_n_o = 1'b1;
        rd_n_o = 1'b1;
    end

    // start pin; callers keep the bus quiet and track long enough first
    task automatic set_start(input logic v);
        @(posedge sys_clk_i);
        start_o <= v;
    endtask

    // power-down pin
    task automatic set_pdown(input logic v);
        @(posedge sys_clk_i);
        pdown_o <= v;
    endtask

    // clock source strap; the external clock stays grounded meanwhile
    task automatic set_strap(input logic v);
        @(posedge sys_clk_i);
        strap_o <= v;
    endtask

    // one 64 ns conversion clock period, well inside 100 kHz to 20 MHz
    task automatic ext_pulse();
        ext_clk_o <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        ext_clk_o <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
    endtask

    // read cycle; tie keeps select low for good, else it follows read
    task automatic read_word(input bit tie, output logic [RESULT_W-1:0] d,
                             output logic [RESULT_W-1:0] d2,
                             output bit ok);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        sel_n_o <= 1'b0;
        rd_n_o <= 1'b0;
        while (oe_i !== 1'b1 && n < 8) begin
            @(posedge sys_clk_i);
            n++;
        end
        d = bus_wire;
        d2 = bus2_wire;
        ok = (n < 8);
        rd_n_o <= 1'b1;
        if (!tie) begin
            sel_n_o <= 1'b1;
        end
        @(posedge sys_clk_i);
    endtask
endmodule // acrc_host_model

// ==== bench/acrc_tb_top.sv ====
// bench top: a host model drives a unipolar and a bipolar converter
// assumes both instances share every pin; only bus contents differ
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin \
    n_errors++; $display("BAD %s exp %h got %h", nm, exp, got); end end
module acrc_tb_top
    import acrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'b0;
    logic arst_n, start, pdown, strap, ext_clk, sel_n, rd_n;
    logic done_n, last_n, oe, shut;
    logic done_b, last_b, oe_b, shut_b;
    logic [RESULT_W-1:0] code, bus, bus_b;
    int n_errors = 0;
    int checked = 0;

    // 250 MHz system clock
    always #2 sys_clk = ~sys_clk;

    acrc_host_model u_host (
        .sys_clk_i(sys_clk), .start_o(start), .pdown_o(pdown),
        .strap_o(strap), .ext_clk_o(ext_clk), .sel_n_o(sel_n),
        .rd_n_o(rd_n), .bus_i(bus), .bus2_i(bus_b), .oe_i(oe)
    );

    acrc_top #(.BIPOLAR(1'b0)) u_dut (
        .sys_clk_i(sys_clk), .arst_n_i(arst_n),
        .sample_convert_start_i(start), .power_down_request_i(pdown),
        .clock_source_select_i(strap), .ext_conv_clk_i(ext_clk),
        .device_select_n_i(sel_n), .read_strobe_n_i(rd_n),
        .sample_code_i(code), .conversion_done_n_o(done_n),
        .last_conversion_done_n_o(last_n), .result_bus_o(bus),
        .result_bus_oe_o(oe), .analog_shutdown_o(shut)
    );

    // second instance formats bipolar words; its flags must match the first
    acrc_top #(.BIPOLAR(1'b1)) u_dut_bip (
        .sys_clk_i(sys_clk), .arst_n_i(arst_n),
        .sample_convert_start_i(start), .power_down_request_i(pdown),
        .clock_source_select_i(strap), .ext_conv_clk_i(ext_clk),
        .device_select_n_i(sel_n), .read_strobe_n_i(rd_n),
        .sample_code_i(code), .conversion_done_n_o(done_b),
        .last_conversion_done_n_o(last_b), .result_bus_o(bus_b),
        .result_bus_oe_o(oe_b), .analog_shutdown_o(shut_b)
    );

    task automatic wrap_up();
        if (n_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // cycles until done falls, capped so a dead flag cannot hang us
    task automatic wait_done(input int lim, output int n);
        n = 0;
        while (done_n !== 1'b0 && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
    endtask

    // read both words, then see the bus released once read goes high
    task automatic do_read(input bit tie, input logic [RESULT_W-1:0] c);
        logic [RESULT_W-1:0] d, d2;
        bit ok;
        u_host.read_word(tie, d, d2, ok);
        `CHK("read_oe", 1'b1, ok)
        `CHK("word_unipolar", c, d)
        `CHK("word_bipolar", {~c[RESULT_W-1], c[RESULT_W-2:0]}, d2)
        repeat (4) @(posedge sys_clk);
        `CHK("bus_released", 2'b00, {oe, oe_b})
    endtask

    // end of sequence: start falls, last-done must clear quickly
    task automatic end_seq();
        // bus must sit idle for at least 50 ns before start falls
        repeat (13) @(posedge sys_clk);
        u_host.set_start(1'b0);
        repeat (5) @(posedge sys_clk);
        `CHK("last_clear", 2'b11, {last_n, last_b})
    endtask

    // internal clock conversion; input moves after the sampling instant
    task automatic s_internal(input logic [RESULT_W-1:0] c, input bit tie);
        int n;
        u_host.set_strap(1'b1);
        code <= c;
        repeat (30) @(posedge sys_clk);
        u_host.set_start(1'b1);
        // clock pin activity mid-conversion must change nothing
        repeat (3) u_host.ext_pulse();
        code <= ~c;
        wait_done(DONE_MAX_CYC, n);
        `CHK("int_in_900ns", 1'b1, n + 48 <= DONE_MAX_CYC)
        `CHK("int_13_periods", 1'b1, n + 48 >= 13 * INT_OSC_CYC)
        `CHK("both_flags", 2'b00, {last_n, last_b})
        repeat (INT_OSC_CYC + 4) @(posedge sys_clk);
        `CHK("done_back_high", 2'b11, {done_n, done_b})
        `CHK("last_still_low", 2'b00, {last_n, last_b})
        do_read(tie, c);
        end_seq();
    endtask

    // external clock: nothing after 12 pulses, flags after the 13th
    task automatic s_external(input logic [RESULT_W-1:0] c);
        u_host.set_strap(1'b0);
        code <= c;
        repeat (30) @(posedge sys_clk);
        u_host.set_start(1'b1);
        repeat (4) @(posedge sys_clk);
        repeat (12) u_host.ext_pulse();
        `CHK("ext_after_12", 2'b11, {done_n, last_n})
        `CHK("ext_12_bip", 2'b11, {done_b, last_b})
        u_host.ext_pulse();
        `CHK("ext_after_13", 2'b00, {done_n, last_n})
        `CHK("ext_13_bip", 2'b00, {done_b, last_b})
        do_read(1'b0, c);
        end_seq();
    endtask

    // start falls mid-conversion: no result may be flagged
    task automatic s_abort();
        int n;
        u_host.set_strap(1'b1);
        repeat (30) @(posedge sys_clk);
        u_host.set_start(1'b1);
        repeat (50) @(posedge sys_clk);
        u_host.set_start(1'b0);
        wait_done(250, n);
        `CHK("abort_no_flag", 250, n)
        `CHK("abort_no_last", 2'b11, {last_n, last_b})
    endtask

    // shutdown with a result pending, read while down, wake converts
    task automatic s_shutdown(input logic [RESULT_W-1:0] c);
        int n;
        code <= c;
        repeat (30) @(posedge sys_clk);
        u_host.set_start(1'b1);
        wait_done(DONE_MAX_CYC, n);
        u_host.set_pdown(1'b1);
        repeat (5) @(posedge sys_clk);
        `CHK("analog_off", 2'b11, {shut, shut_b})
        `CHK("flags_high_sd", 2'b11, {done_n, last_n})
        `CHK("flags_sd_bip", 2'b11, {done_b, last_b})
        do_read(1'b0, c);
        code <= ~c;
        u_host.set_pdown(1'b0);
        wait_done(DONE_MAX_CYC, n);
        `CHK("wake_converts", 1'b1, n < DONE_MAX_CYC)
        `CHK("analog_on", 2'b00, {shut, shut_b})
        do_read(1'b1, ~c);
        end_seq();
    endtask

    // watchdog: the whole sequence needs well under 10000 cycles
    initial begin
        repeat (40000) @(posedge sys_clk);
        n_errors++;
        wrap_up();
    end

    // main sequence
    initial begin
        logic [RESULT_W-1:0] codes [4];
        codes = '{12'h000, 12'h7FF, 12'h800, 12'hFFF};
        arst_n = 1'b0;
        code = 12'h000;
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        // first result after power-up is checked like any other
        s_internal(12'h555, 1'b0);
        foreach (codes[i]) begin
            s_internal(codes[i], i[0]);
        end
        s_external(12'hA5A);
        s_external(12'h801);
        s_abort();
        s_internal(12'h123, 1'b0);
        s_shutdown(12'h3C6);
        wrap_up();
    end
endmodule // acrc_tb_top

// ==== include/acrc_pkg.sv ====
// shared constants, types and helpers of the converter sequencing block
// assumes one 250 MHz system clock and an active-low asynchronous reset
package acrc_pkg;

    // clock and timing
    localparam int SYS_CLK_PERIOD_NS = 4;
    localparam int INT_OSC_PERIOD_NS = 64; // internal oscillator, ~15.6 MHz
    localparam int INT_OSC_CYC = INT_OSC_PERIOD_NS / SYS_CLK_PERIOD_NS;
    localparam int DONE_MAX_NS = 900; // internal mode start to done
    localparam int DONE_MAX_CYC = DONE_MAX_NS / SYS_CLK_PERIOD_NS;

    // conversion shape
    localparam int RESULT_W = 12;
    localparam int CONV_PERIODS = 13;
    localparam int CONV_CNT_W = 4;
    localparam logic [CONV_CNT_W-1:0] CONV_LAST = 4'hC; // 13th period

    // synchronised pin vector layout
    localparam int PIN_W = 6;
    localparam int PIN_START = 0;
    localparam int PIN_PDOWN = 1;
    localparam int PIN_SEL_N = 2;
    localparam int PIN_RD_N = 3;
    localparam int PIN_CLKSEL = 4;
    localparam int PIN_EXTCLK = 5;
    // strobes idle high, everything else idles low
    localparam logic [PIN_W-1:0] PIN_RST = 6'h0C;

    // sequencer states, gray order along track -> convert -> ready
    typedef enum logic [1:0] {
        ST_TRACK = 2'h0,
        ST_CONVERT = 2'h1,
        ST_READY = 2'h3,
        ST_SHUTDOWN = 2'h2
    } acrc_state_e;

    // registered state of the top level, apart from the helper counters that only the checks read
    typedef struct packed {
        acrc_state_e st;
        logic [CONV_CNT_W-1:0] cnt;
        logic start_d;
        logic pdown_d;
        logic done_n;
        logic last_n;
        logic [RESULT_W-1:0] sample;
        logic [RESULT_W-1:0] result;
        logic oe;
        logic [RESULT_W-1:0] bus;
        logic shutdown;
    } acrc_top_s;

    localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;

    // offset binary from the core; bipolar parts flip the msb
    function automatic logic [RESULT_W-1:0] acrc_format(
        input logic [RESULT_W-1:0] code,
        input logic bipolar
    );
        logic [RESULT_W-1:0] res;
        res = code;
        if (bipolar) begin
            res[RESULT_W-1] = ~code[RESULT_W-1];
        end
        return res;
    endfunction

endpackage

// ==== rtl/acrc_conv_tick.sv ====
// conversion clock source: internal divider or external clock edges
// assumes the external clock level is already synchronised
module acrc_conv_tick
    import acrc_pkg::*;
#(
    parameter int OSC_CYC = INT_OSC_CYC
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // control
    input wire logic int_mode_i,
    input wire logic run_i,
    input wire logic ext_clk_i,
    // one-cycle pulse per conversion clock rising edge
    output logic tick_o
);

    localparam int DIV_W = $clog2(OSC_CYC + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_CYC - 1);

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic ext_d;
        logic tick;
    } acrc_tick_s;

    acrc_tick_s q;
    acrc_tick_s next_q;

    // the divider restarts with every conversion so timing is repeatable
    always_comb begin
        next_q = q;
        next_q.ext_d = ext_clk_i;
        next_q.tick = 1'b0;
        if (!run_i) begin
            next_q.div = '0;
        end else if (int_mode_i) begin
            // external pin is ignored here [RULE22] [RULE2]
            if (q.div == DIV_LAST) begin
                next_q.div = '0;
                next_q.tick = 1'b1;
            end else begin
                next_q.div = q.div + DIV_W'(1);
            end
        end else begin
            next_q.tick = ext_clk_i & ~q.ext_d;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign tick_o = q.tick;

endmodule // acrc_conv_tick

// ==== rtl/acrc_sync.sv ====
// two-stage synchroniser for a vector of independent pin levels
// assumes each bit is a slow level; no bit relation is preserved
module acrc_sync
    import acrc_pkg::*;
#(
    parameter int W = PIN_W,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // pins
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } acrc_sync_s;

    acrc_sync_s q;
    acrc_sync_s next_q;

    // first stage feeds only the second stage
    always_comb begin
        next_q.s1 = async_i;
        next_q.s2 = q.s1;
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= {RST_VAL, RST_VAL};
        end else begin
            q <= next_q;
        end
    end

    assign sync_o = q.s2;

endmodule // acrc_sync

// ==== rtl/acrc_top.sv ====
// sequencing and parallel readout of a 12-bit sampling converter
// assumes the analog core presents its code on sample_code_i in this clock
//
// Behaviour
// RULE1 - every conversion lasts exactly 13 conversion clock periods
// RULE2 - strap high selects the internal oscillator for conversions
// RULE3 - external mode: host ties strap low, clock 100kHz to 20MHz
// RULE4 - host holds start low to track; rising edge samples and converts
// RULE5 - external mode: first clock pulse within 10us of start rising
// RULE6 - external mode: done flags fall on the 13th clock rising edge
// RULE7 - internal mode: done flags fall within 900ns of start rising
// RULE8 - both done flags pulse low whenever a new result is ready
// RULE9 - start falling mid-conversion aborts it and begins new acquisition
// RULE10 - host keeps its bus quiet 50ns before start falls
// RULE11 - select and read low drive the 12-bit result onto the bus
// RULE12 - bus floats whenever select or read is high
// RULE13 - host may hold select low, pulse it, or tie it to read
// RULE14 - after power-up wait 1ms and discard one conversion
// RULE15 - power-down request high shuts down, both done flags held high
// RULE16 - bus drive depends only on select and read, even in shutdown
// RULE17 - power-down release starts a conversion like start rising
// RULE18 - unipolar variant gives offset binary results
// RULE19 - bipolar variants give two's complement results
// RULE20 - done returns high on next conversion clock edge or start falling
// RULE21 - last-done returns high when start falls
// RULE22 - internal mode ignores the external clock pin entirely
module acrc_top
    import acrc_pkg::*;
#(
    parameter bit BIPOLAR = 1'b0,
    parameter int OSC_CYC = INT_OSC_CYC
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // conversion control pins
    input wire logic sample_convert_start_i,
    input wire logic power_down_request_i,
    input wire logic clock_source_select_i,
    input wire logic ext_conv_clk_i,
    // read interface pins
    input wire logic device_select_n_i,
    input wire logic read_strobe_n_i,
    // analog core result, offset binary
    input wire logic [RESULT_W-1:0] sample_code_i,
    // status pins
    output logic conversion_done_n_o,
    output logic last_conversion_done_n_o,
    // tri-state result bus
    output logic [RESULT_W-1:0] result_bus_o,
    output logic result_bus_oe_o,
    // analog section power-down
    output logic analog_shutdown_o
);

    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins;
    logic tick;
    logic start_s;
    logic pdown_s;
    logic int_mode;
    logic run;
    logic start_rise;
    logic start_fall;
    logic pdown_fall;
    acrc_top_s q;
    acrc_top_s next_q;

    // every pin passes two flops before any logic reads it
    always_comb begin
        pins_raw = '0;
        pins_raw[PIN_START] = sample_convert_start_i;
        pins_raw[PIN_PDOWN] = power_down_request_i;
        pins_raw[PIN_SEL_N] = device_select_n_i;
        pins_raw[PIN_RD_N] = read_strobe_n_i;
        pins_raw[PIN_CLKSEL] = clock_source_select_i;
        pins_raw[PIN_EXTCLK] = ext_conv_clk_i;
    end

    acrc_sync #(
        .W(PIN_W),
        .RST_VAL(PIN_RST)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .async_i(pins_raw),
        .sync_o(pins)
    );

    // the divider only runs while a conversion or its result is live
    assign run = (q.st == ST_CONVERT) || (q.st == ST_READY);
    assign int_mode = pins[PIN_CLKSEL]; // [RULE2]

    acrc_conv_tick #(
        .OSC_CYC(OSC_CYC)
    ) u_tick (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .int_mode_i(int_mode),
        .run_i(run),
        .ext_clk_i(pins[PIN_EXTCLK]),
        .tick_o(tick)
    );

    // edge detection on the synchronised control levels
    assign start_s = pins[PIN_START];
    assign pdown_s = pins[PIN_PDOWN];
    assign start_rise = start_s & ~q.start_d;
    assign start_fall = ~start_s & q.start_d;
    assign pdown_fall = ~pdown_s & q.pdown_d;

    // sequencer: track, convert, ready, shutdown
    always_comb begin
        next_q = q;
        next_q.start_d = start_s;
        next_q.pdown_d = pdown_s;
        next_q.shutdown = pdown_s;
        // bus drive follows only select and read [RULE12] [RULE16] [RULE11]
        next_q.oe = ~pins[PIN_SEL_N] & ~pins[PIN_RD_N];
        next_q.bus = q.result;
        if (pdown_s) begin
            // shutdown overrides any conversion in flight [RULE15]
            next_q.st = ST_SHUTDOWN;
            next_q.cnt = '0;
            next_q.done_n = 1'b1;
            next_q.last_n = 1'b1;
        end else begin
            unique case (q.st)
                ST_SHUTDOWN: begin
                    if (pdown_fall) begin
                        // release samples like a start edge [RULE17]
                        next_q.st = ST_CONVERT;
                        next_q.cnt = '0;
                        next_q.sample = sample_code_i;
                    end else begin
                        next_q.st = ST_TRACK;
                    end
                end
                ST_TRACK: begin
                    if (start_rise) begin
                        // sampling instant is the start rising edge [RULE4]
                        next_q.st = ST_CONVERT;
                        next_q.cnt = '0;
                        next_q.sample = sample_code_i;
                    end
                end
                ST_CONVERT: begin
                    if (start_fall) begin
                        // abort; tracking resumes for a new cycle [RULE9]
                        next_q.st = ST_TRACK;
                        next_q.cnt = '0;
                    end else if (tick) begin
                        if (q.cnt == CONV_LAST) begin
                            // 13th edge ends it [RULE1] [RULE6] [RULE7]
                            next_q.st = ST_READY;
                            // coding follows the variant [RULE18] [RULE19]
                            next_q.result = acrc_format(q.sample, BIPOLAR);
                            next_q.done_n = 1'b0; // [RULE8]
                            next_q.last_n = 1'b0;
                        end else begin
                            next_q.cnt = q.cnt + CONV_CNT_W'(1);
                        end
                    end
                end
                ST_READY: begin
                    if (start_fall) begin
                        // next sequence begins; both flags clear [RULE21]
                        next_q.st = ST_TRACK;
                        next_q.cnt = '0;
                        next_q.done_n = 1'b1;
                        next_q.last_n = 1'b1;
                    end else if (tick) begin
                        next_q.done_n = 1'b1; // [RULE20]
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q.st <= ST_TRACK;
            q.cnt <= '0;
            q.start_d <= 1'b0;
            q.pdown_d <= 1'b0;
            q.done_n <= 1'b1;
            q.last_n <= 1'b1;
            q.sample <= RESULT_RST;
            q.result <= RESULT_RST;
            q.oe <= 1'b0;
            q.bus <= RESULT_RST;
            q.shutdown <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

    // all outputs straight from the state register
    assign conversion_done_n_o = q.done_n;
    assign last_conversion_done_n_o = q.last_n;
    assign result_bus_o = q.bus;
    assign result_bus_oe_o = q.oe;
    assign analog_shutdown_o = q.shutdown;

    // helper counters that only the checks read
    int unsigned tick_h;
    int unsigned lat_h;
    int unsigned gap_h;
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tick_h <= 0;
            lat_h <= 0;
            gap_h <= 0;
        end else begin
            if (q.st != ST_CONVERT) begin
                tick_h <= 0;
            end else if (tick) begin
                tick_h <= tick_h + 1;
            end
            // restart on each entry to convert, start edge or wake-up
            if (q.st != ST_CONVERT && next_q.st == ST_CONVERT) begin
                lat_h <= 1;
            end else if (lat_h != 0) begin
                lat_h <= lat_h + 1;
            end
            // gap since the previous tick, the tick cycle counting as one
            if (!run) begin
                gap_h <= 0;
            end else if (tick) begin
                gap_h <= 1;
            end else begin
                gap_h <= gap_h + 1;
            end
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    localparam int LAT_LIMIT = DONE_MAX_CYC;

    chk_conv_len: assert property ( // [RULE1] [RULE6]
        (q.st == ST_CONVERT && next_q.st == ST_READY)
            |-> (tick_h == CONV_PERIODS - 1 && tick))
        else $error("conversion did not end on the 13th clock edge");

    chk_int_latency: assert property ( // [RULE7]
        ($fell(conversion_done_n_o) && int_mode && lat_h != 0)
            |-> (lat_h <= LAT_LIMIT))
        else $error("internal mode done later than 900ns");

    chk_tick_regular: assert property ( // [RULE22]
        (int_mode && run && tick) |-> (gap_h == OSC_CYC))
        else $error("internal tick spacing disturbed");

    chk_flags_both: assert property ( // [RULE8]
        $fell(conversion_done_n_o) |-> $fell(last_conversion_done_n_o))
        else $error("done flags did not fall together");

    chk_abort_track: assert property ( // [RULE9]
        (q.st == ST_CONVERT && start_fall && !pdown_s)
            |=> (q.st == ST_TRACK && conversion_done_n_o))
        else $error("start fall did not abort the conversion");

    chk_bus_drive: assert property ( // [RULE12]
        (pins[PIN_SEL_N] || pins[PIN_RD_N]) |=> !result_bus_oe_o)
        else $error("result bus driven with select or read high");

    chk_bus_power_down_request: assert property ( // [RULE16]
        (!pins[PIN_SEL_N] && !pins[PIN_RD_N]) |=> result_bus_oe_o)
        else $error("result bus not driven with select and read low");

    chk_power_down_request_flags: assert property ( // [RULE15]
        pdown_s |=> (conversion_done_n_o && last_conversion_done_n_o))
        else $error("done flags low during shutdown");

    chk_pdown_exit: assert property ( // [RULE17]
        (q.st == ST_SHUTDOWN && pdown_fall)
            |=> (q.st == ST_CONVERT && q.sample == $past(sample_code_i)))
        else $error("shutdown release did not start a conversion");

    chk_result_code: assert property ( // [RULE18] [RULE19]
        $fell(conversion_done_n_o)
            |-> (q.result == {q.sample[RESULT_W-1] ^ BIPOLAR,
                              q.sample[RESULT_W-2:0]}))
        else $error("result coding does not match the variant");

    chk_done_release: assert property ( // [RULE20]
        (q.st == ST_READY && !conversion_done_n_o && tick && !pdown_s)
            |=> conversion_done_n_o)
        else $error("done not released on the next clock edge");

    chk_last_release: assert property ( // [RULE21]
        (q.st == ST_READY && start_fall && !pdown_s)
            |=> (last_conversion_done_n_o && q.st == ST_TRACK))
        else $error("last-done not released on start fall");

    cov_full_conv: cover property (
        $fell(conversion_done_n_o) ##[1:300] $fell(start_s));

    cov_abort: cover property (q.st == ST_CONVERT && start_fall);

    cov_pdown_conv: cover property (
        (q.st == ST_SHUTDOWN && pdown_fall) ##[1:300]
            $fell(conversion_done_n_o));

    cov_read: cover property ($rose(result_bus_oe_o) && q.st == ST_READY);

endmodule // acrc_top
